/* File: bench/cpu_partner.sv */
module cpu_partner
  import console_bridge_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [DATA_W-1:0]     to_cpu_data,
  input  wire logic                  to_cpu_full,
  output logic                       to_cpu_take,
  output logic      [DATA_W-1:0]     last_word,
  input  wire logic                  tx_req,
  input  wire term_char_s            tx_char,
  output term_char_s                 cpu_tx,
  output logic                       cpu_tx_valid,
  input  wire logic                  cpu_tx_ready,
  input  wire ib_ctrl_s              ib_ctrl,
  input  wire logic [DATA_W-1:0]     ib_data_out,
  input  wire logic                  ib_data_oe_n,
  output logic      [DATA_W-1:0]     ib_data_in,
  output logic      [SCAN_LANES-1:0] scan_lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] regs [256];
  logic [1:0]        dly;
  initial for (int i = 0; i < 256; i++) regs[i] <= {24'h5A_0000, 8'(i)};
  // test points stay steady while the cpu is halted
  assign scan_lanes = 8'hA5;
  always @(posedge clk) begin
    if (!rst_n) begin
      to_cpu_take  <= 1'b0;
      dly          <= 2'h0;
      cpu_tx_valid <= 1'b0;
      cpu_tx       <= 12'h000;
      ib_data_in   <= 32'h0000_0000;
      last_word    <= 32'h0000_0000;
    end else begin
      to_cpu_take <= 1'b0;
      // microcode is slow: takes the word a few cycles late
      if (to_cpu_full && !to_cpu_take) begin
        dly <= dly + 2'h1;
        if (dly == 2'h2) begin
          to_cpu_take <= 1'b1;
          last_word   <= to_cpu_data;
          dly         <= 2'h0;
        end
      end
      if (tx_req) begin
        cpu_tx_valid <= 1'b1;
        cpu_tx       <= tx_char;
      end else if (cpu_tx_valid && cpu_tx_ready) begin
        cpu_tx_valid <= 1'b0;
        cpu_tx       <= ~cpu_tx;
      end
      // released bus toggles so a stale sample never passes
      if (ib_ctrl.req && !ib_ctrl.write) ib_data_in <= regs[ib_ctrl.addr];
      else ib_data_in <= ~ib_data_in;
      if (ib_ctrl.req && ib_ctrl.write && !ib_data_oe_n) regs[ib_ctrl.addr] <= ib_data_out;
    end
  end
endmodule : cpu_partner

/* File: bench/test_console_mode_bridge.sv */
module test_console_mode_bridge;
  timeunit 1ns;
  timeprecision 1ps;
  import console_bridge_pkg::*;
  logic clk = 0, rst_n = 0, cpu_error_halt = 0, term_in_valid = 0, term_out_take = 0, tx_req = 0;
  console_cmd_s cmd = '0;
  term_char_s term_in = '0, tx_char = '0, term_out, cpu_tx;
  logic cmd_done, cmd_refused, term_in_ready, term_out_valid, to_cpu_full, to_cpu_take;
  logic cpu_tx_valid, cpu_tx_ready, cpu_run, cpu_step, cmd_mode, ib_data_oe_n, scan_load, scan_clk;
  logic [DATA_W-1:0] rsp_data, to_cpu_data, ib_data_out, ib_data_in, last_word;
  logic [SCAN_LANES-1:0] scan_lanes;
  ib_ctrl_s ib_ctrl;
  int n_fail = 0, comparisons = 0;
  logic rf;
  logic [3:0] sw;
  always #2.5 clk = ~clk;

  console_mode_bridge u_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cmd(cmd),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused), .rsp_data(rsp_data), .term_in(term_in),
    .term_in_valid(term_in_valid), .term_in_ready(term_in_ready), .term_out(term_out),
    .term_out_valid(term_out_valid), .term_out_take(term_out_take), .to_cpu_data(to_cpu_data),
    .to_cpu_full(to_cpu_full), .to_cpu_take(to_cpu_take), .cpu_tx(cpu_tx),
    .cpu_tx_valid(cpu_tx_valid), .cpu_tx_ready(cpu_tx_ready), .cpu_error_halt(cpu_error_halt),
    .cpu_run(cpu_run), .cpu_step(cpu_step), .cmd_mode(cmd_mode), .ib_ctrl(ib_ctrl),
    .ib_data_out(ib_data_out), .ib_data_oe_n(ib_data_oe_n), .ib_data_in(ib_data_in),
    .scan_load(scan_load), .scan_clk(scan_clk), .scan_lanes(scan_lanes));

  cpu_partner u_cpu (.clk(clk), .rst_n(rst_n), .to_cpu_data(to_cpu_data),
    .to_cpu_full(to_cpu_full), .to_cpu_take(to_cpu_take), .last_word(last_word),
    .tx_req(tx_req), .tx_char(tx_char), .cpu_tx(cpu_tx), .cpu_tx_valid(cpu_tx_valid),
    .cpu_tx_ready(cpu_tx_ready), .ib_ctrl(ib_ctrl), .ib_data_out(ib_data_out),
    .ib_data_oe_n(ib_data_oe_n), .ib_data_in(ib_data_in), .scan_lanes(scan_lanes));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
    end
  endtask : check

  // flags seen while waiting: {scan_clk, scan_load, bus driven, request}
  task automatic do_cmd(input cmd_e code, input logic [7:0] addr, input logic [31:0] data);
    int i;
    sw = 4'h0;
    @(posedge clk);
    cmd <= {1'b1, code, 1'b0, addr, data};
    @(posedge clk);
    cmd.valid <= 1'b0;
    for (i = 0; i < 12; i++) begin
      #1;
      sw |= {scan_clk, scan_load, !ib_data_oe_n, ib_ctrl.req};
      if (cmd_done === 1'b1 || cmd_refused === 1'b1) break;
      @(posedge clk);
    end
    check(i < 12, 1, "command answer");
    rf = cmd_refused;
  endtask : do_cmd

  task automatic send_term(input logic [3:0] unit, input logic [7:0] ch);
    int i;
    @(posedge clk);
    term_in <= {unit, ch};
    term_in_valid <= 1'b1;
    // hold valid until an edge that sees ready high; drop it at that edge
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (term_in_ready !== 1'b1 && i < 20);
    term_in_valid <= 1'b0;
    for (i = 0; i < 20 && to_cpu_take !== 1'b1; i++) @(posedge clk);
    check(last_word, {20'h0, unit, ch}, "word at cpu");
  endtask : send_term

  task automatic t_reset;
    check(cpu_run, 0, "run after reset");
    check(cmd_mode, 1, "mode after reset");
    check(ib_data_oe_n, 1, "bus idle");
  endtask : t_reset

  task automatic t_halted;
    do_cmd(CMD_SHOW, 8'h00, 32'h0);
    check(rsp_data, 32'h0000_0002, "show flags");
    do_cmd(CMD_PROGRAM, 8'h00, 32'h0);
    check(rf, 1, "program while halted");
    do_cmd(CMD_MAINT_WR, 8'h3C, 32'hDEAD_BEEF);
    check({rf, sw[1:0]}, 3'b011, "maint write");
    do_cmd(CMD_MAINT_RD, 8'h3C, 32'h0);
    check({rf, sw[1:0]}, 3'b001, "maint read");
    check(rsp_data, 32'hDEAD_BEEF, "read back");
    do_cmd(CMD_MAINT_RD, 8'h11, 32'h0);
    check(rsp_data, 32'h5A00_0011, "read reg");
    do_cmd(CMD_STEP, 8'h00, 32'h0);
    check({rf, cpu_step}, 2'b01, "step halted");
    do_cmd(CMD_NONE, 8'h00, 32'h0);
    check(rf, 1, "empty command");
  endtask : t_halted

  task automatic t_scan;
    do_cmd(CMD_SCAN_LOAD, 8'h00, 32'h0);
    check({rf, sw[2]}, 2'b01, "load pulse");
    do_cmd(CMD_SCAN_SHIFT, 8'h00, 32'h0);
    check({rf, sw[3]}, 2'b01, "shift clock");
    do_cmd(CMD_SCAN_SHIFT, 8'h00, 32'h0);
    check(rf, 1, "shift before read");
    do_cmd(CMD_SCAN_READ, 8'h00, 32'h0);
    check(rsp_data[7:0], 8'hA5, "capture");
    do_cmd(CMD_SCAN_SHIFT, 8'h00, 32'h0);
    check(rf, 0, "shift after read");
  endtask : t_scan

  task automatic t_program;
    cmd_e ok [5] = '{CMD_SHOW, CMD_SET, CMD_WAIT_DONE, CMD_HELP, CMD_CLEAR};
    cmd_e no [3] = '{CMD_MAINT_RD, CMD_STEP, CMD_DIAG};
    int i;
    do_cmd(CMD_CONTINUE, 8'h00, 32'h0);
    check({rf, cpu_run, cmd_mode}, 3'b010, "continue");
    send_term(4'h3, 8'h41);
    send_term(4'h0, 8'h42);
    @(posedge clk);
    tx_char <= {4'h0, 8'h52};
    tx_req <= 1'b1;
    @(posedge clk);
    tx_req <= 1'b0;
    for (i = 0; i < 20 && term_out_valid !== 1'b1; i++) @(posedge clk);
    check(term_out, 12'h052, "cpu char out");
    term_out_take <= 1'b1;
    @(posedge clk);
    term_out_take <= 1'b0;
    do_cmd(CMD_SHOW, 8'h00, 32'h0);
    check(rf, 1, "command in program mode");
    do_cmd(CMD_SCAN_LOAD, 8'h00, 32'h0);
    check(rf, 1, "scan in program mode");
    do_cmd(CMD_ESCAPE, 8'h00, 32'h0);
    check({rf, cpu_run, cmd_mode}, 3'b011, "escape");
    @(posedge clk);
    term_in_valid <= 1'b1;
    for (i = 0; i < 5; i++) begin
      do_cmd(ok[i], 8'h00, 32'h0);
      check(rf, 0, "allowed running");
    end
    for (i = 0; i < 3; i++) begin
      do_cmd(no[i], 8'h00, 32'h0);
      check(rf, 1, "barred running");
    end
    check({term_in_ready, cpu_tx_ready}, 2'b00, "cpu cut off");
    @(posedge clk);
    term_in_valid <= 1'b0;
    do_cmd(CMD_HALT, 8'h00, 32'h0);
    check({rf, cpu_run, cmd_mode}, 3'b001, "halt");
  endtask : t_program

  task automatic t_error;
    do_cmd(CMD_CONTINUE, 8'h00, 32'h0);
    @(posedge clk);
    cpu_error_halt <= 1'b1;
    @(posedge clk);
    cpu_error_halt <= 1'b0;
    #1;
    check({cpu_run, cmd_mode}, 2'b01, "error halt");
    do_cmd(CMD_SHOW, 8'h00, 32'h0);
    check(rsp_data, 32'h0000_0002, "state after error");
  endtask : t_error

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_halted();
    t_scan();
    t_program();
    t_error();
    final_report();
  end
endmodule : test_console_mode_bridge

/* File: rtl/console_bridge_pkg.sv */
// Function
// R1: cpu traffic passes only through the to-cpu and from-cpu data registers
// R2: cpu runs or halts; halt by error, or halt command in command mode
// R3: an error halt forces the console into command mode at once
// R4: program mode forwards each terminal character singly to the cpu
// R5: program mode passes cpu output unchanged to the terminal
// R6: program mode never treats terminal input as console commands
// R7: command mode routes terminal traffic to the console interpreter
// R8: running in command mode, halt stops the cpu, continue resumes it
// R9: a continue from command mode switches to program mode
// R10: to halt from program mode, controller enters command mode first
// R11: running in command mode only cpu-silent commands and halt are taken
// R12: running in command mode, nothing passes to or from cpu software
// R13: halted with program mode is useless; leave it at once
// R14: halted in command mode, the whole command set is taken; code refuses CMD_PROGRAM while halted
// R15: scan bus is used only in command mode
// R16: maintenance request drives internal bus address, control, write data
// R17: maintenance gives read and write of control store and registers
// R18: to-cpu register holds character low byte, unit in bits 11 to 8
// R19: maintenance reads return through from-cpu register, cpu halted only
// R20: load captures scan points; capture read before each next shift
// R21: console mode and run state are flags both sides can read
package console_bridge_pkg;
  localparam int DATA_W        = 32;
  localparam int CHAR_W        = 8;
  localparam int UNIT_W        = 4;
  localparam int IB_ADDR_W     = 8;
  localparam int SCAN_LANES    = 8;
  localparam int SYNC_STAGES   = 2;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MAINT_HOLD_NS = 20;
  localparam int MAINT_CYCLES  = (MAINT_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCAN_SETTLE_NS = 15;
  localparam int SCAN_WAIT     =
    (SCAN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STAGES;
  localparam int CNT_W         = 4;
  localparam logic [UNIT_W-1:0] OPERATOR_UNIT = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 32'h0000_0000;

  typedef enum logic [4:0] {
    CMD_NONE      = 5'h00,
    CMD_HALT      = 5'h01,
    CMD_CONTINUE  = 5'h02,
    CMD_SHOW      = 5'h03,
    CMD_SET       = 5'h04,
    CMD_WAIT_DONE = 5'h05,
    CMD_HELP      = 5'h06,
    CMD_SCAN_LOAD = 5'h07,
    CMD_SCAN_SHIFT = 5'h08,
    CMD_SCAN_READ = 5'h09,
    CMD_CLEAR     = 5'h0A,
    CMD_MAINT_RD  = 5'h0B,
    CMD_MAINT_WR  = 5'h0C,
    CMD_STEP      = 5'h0D,
    CMD_START     = 5'h0E,
    CMD_DIAG      = 5'h0F,
    CMD_ESCAPE    = 5'h10,
    CMD_PROGRAM   = 5'h11
  } cmd_e;

  typedef enum logic [3:0] {
    M_IDLE   = 4'b0001,
    M_DRIVE  = 4'b0010,
    M_SAMPLE = 4'b0100,
    M_DONE   = 4'b1000
  } maint_state_e;

  typedef struct packed {
    logic [UNIT_W-1:0] unit;
    logic [CHAR_W-1:0] ch;
  } term_char_s;

  typedef struct packed {
    logic                 valid;
    cmd_e                 code;
    logic                 space;
    logic [IB_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]    data;
  } console_cmd_s;

  typedef struct packed {
    logic                 req;
    logic                 write;
    logic                 space;
    logic [IB_ADDR_W-1:0] addr;
  } ib_ctrl_s;
endpackage : console_bridge_pkg

/* File: rtl/console_mode_bridge.sv */
module console_mode_bridge
  import console_bridge_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire console_cmd_s          cmd,
  output logic                       cmd_done,
  output logic                       cmd_refused,
  output logic      [DATA_W-1:0]     rsp_data,
  input  wire term_char_s            term_in,
  input  wire logic                  term_in_valid,
  output logic                       term_in_ready,
  output term_char_s                 term_out,
  output logic                       term_out_valid,
  input  wire logic                  term_out_take,
  output logic      [DATA_W-1:0]     to_cpu_data,
  output logic                       to_cpu_full,
  input  wire logic                  to_cpu_take,
  input  wire term_char_s            cpu_tx,
  input  wire logic                  cpu_tx_valid,
  output logic                       cpu_tx_ready,
  input  wire logic                  cpu_error_halt,
  output logic                       cpu_run,
  output logic                       cpu_step,
  output logic                       cmd_mode,
  output ib_ctrl_s                   ib_ctrl,
  output logic      [DATA_W-1:0]     ib_data_out,
  output logic                       ib_data_oe_n,
  input  wire logic [DATA_W-1:0]     ib_data_in,
  output logic                       scan_load,
  output logic                       scan_clk,
  input  wire logic [SCAN_LANES-1:0] scan_lanes
);
  logic [DATA_W-1:0]     from_cpu_data;
  logic                  from_cpu_full;
  logic [SCAN_LANES-1:0] lanes_sync;
  logic [SCAN_LANES-1:0] capture;
  logic                  scan_unread;
  logic                  scan_busy;
  logic [CNT_W-1:0]      scan_cnt;
  logic                  scan_sample;
  maint_state_e          mstate;
  logic [CNT_W-1:0]      mcnt;
  logic                  acc;
  logic                  refuse;
  logic                  imm_done;
  logic                  run_ok;
  logic                  acc_term;
  logic                  acc_tx;
  logic                  next_run;
  logic                  next_mode;
  logic                  next_rx_full;
  logic                  next_tx_full;

  pin_sync #(
    .W (SCAN_LANES)
  ) u_scan_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (scan_lanes),
    .q     (lanes_sync)
  );

  scan_capture #(
    .LANES (SCAN_LANES)
  ) u_scan_cap (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .sample  (scan_sample),
    .lanes   (lanes_sync),
    .capture (capture)
  );

  // both data registers are the only cpu path; no bypass exists [R1]
  assign term_out    = from_cpu_data[UNIT_W+CHAR_W-1:0];
  assign ib_data_out = to_cpu_data;
  assign acc_term    = term_in_valid && term_in_ready && clk_en;
  assign acc_tx      = cpu_tx_valid && cpu_tx_ready && clk_en;
  assign scan_sample = scan_busy && (scan_cnt == CNT_W'(SCAN_WAIT));

  // commands that need nothing back from a running cpu [R11]
  always_comb begin
    case (cmd.code)
      CMD_HALT, CMD_CONTINUE, CMD_SHOW, CMD_SET, CMD_WAIT_DONE,
      CMD_HELP, CMD_SCAN_LOAD, CMD_SCAN_SHIFT, CMD_SCAN_READ,
      CMD_CLEAR, CMD_PROGRAM, CMD_ESCAPE: run_ok = 1'b1;
      default:                            run_ok = 1'b0;
    endcase
  end

  // command gate; escape is the controller's own mode switch [R10]
  always_comb begin
    acc      = 1'b0;
    refuse   = 1'b0;
    imm_done = 1'b0;
    if (cmd.valid && clk_en) begin
      if (cmd.code == CMD_ESCAPE) begin
        acc = 1'b1;
      end else if (!cmd_mode || cpu_error_halt) begin
        refuse = 1'b1; // [R6]
      end else if (mstate != M_IDLE || cmd.code == CMD_NONE) begin
        refuse = 1'b1;
      end else if (cpu_run && !run_ok) begin
        refuse = 1'b1; // [R11] [R12]
      end else if (cmd.code == CMD_PROGRAM && !cpu_run) begin
        refuse = 1'b1; // [R13]
      end else if (cmd.code == CMD_SCAN_SHIFT && (scan_unread || scan_busy)) begin
        refuse = 1'b1; // [R20]
      end else begin
        acc = 1'b1; // [R7] [R14]
      end
      case (cmd.code)
        CMD_MAINT_RD, CMD_MAINT_WR, CMD_SCAN_SHIFT: imm_done = 1'b0;
        default:                                    imm_done = acc;
      endcase
    end
  end

  always_comb begin
    next_run  = cpu_run;
    next_mode = cmd_mode;
    if (cpu_error_halt && clk_en) begin
      next_run  = 1'b0; // [R2]
      next_mode = 1'b1; // [R3]
    end else if (acc) begin
      case (cmd.code)
        CMD_HALT: next_run = 1'b0; // [R2] [R8]
        CMD_CONTINUE, CMD_START: begin
          next_run  = 1'b1; // [R8]
          next_mode = 1'b0; // [R9]
        end
        CMD_ESCAPE:  next_mode = 1'b1;
        CMD_PROGRAM: next_mode = 1'b0;
        default: next_mode = cmd_mode;
      endcase
    end
    if (!next_run) begin
      next_mode = 1'b1; // [R13]
    end
  end

  // run and mode flags, readable by both sides [R21]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_run  <= 1'b0;
      cmd_mode <= 1'b1;
    end else begin
      cpu_run  <= next_run;
      cmd_mode <= next_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_step <= 1'b0;
    end else if (clk_en) begin
      cpu_step <= acc && cmd.code == CMD_STEP; // [R14]
    end
  end

  always_comb begin
    next_rx_full = to_cpu_full;
    if (to_cpu_take && clk_en) begin
      next_rx_full = 1'b0;
    end
    if (acc_term) begin
      next_rx_full = 1'b1;
    end
  end

  always_comb begin
    next_tx_full = from_cpu_full;
    if (term_out_take && term_out_valid && clk_en) begin
      next_tx_full = 1'b0;
    end
    if (acc_tx) begin
      next_tx_full = 1'b1;
    end
  end

  // to-cpu register: terminal characters, or maintenance write data [R18]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      to_cpu_data <= DATA_ZERO;
      to_cpu_full <= 1'b0;
    end else if (clk_en) begin
      to_cpu_full <= next_rx_full;
      if (acc_term) begin
        to_cpu_data <= {{(DATA_W-UNIT_W-CHAR_W){1'b0}}, term_in}; // [R4] [R18]
      end else if (acc && cmd.code == CMD_MAINT_WR) begin
        to_cpu_data <= cmd.data; // [R16]
      end
    end
  end

  // terminal input goes to the cpu only in program mode [R4] [R6] [R12]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_in_ready <= 1'b0;
    end else if (clk_en) begin
      term_in_ready <= next_run && !next_mode && !next_rx_full;
    end
  end

  // from-cpu register: cpu output, or maintenance read data [R19]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      from_cpu_data <= DATA_ZERO;
      from_cpu_full <= 1'b0;
    end else if (clk_en) begin
      from_cpu_full <= next_tx_full;
      if (acc_tx) begin
        from_cpu_data <= {{(DATA_W-UNIT_W-CHAR_W){1'b0}}, cpu_tx}; // [R5]
      end else if (mstate == M_SAMPLE && !ib_ctrl.write) begin
        from_cpu_data <= ib_data_in; // [R17] [R19]
      end
    end
  end

  // a char held across a mode change waits; a maintenance read can overwrite it [R5] [R12]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_tx_ready   <= 1'b0;
      term_out_valid <= 1'b0;
    end else if (clk_en) begin
      cpu_tx_ready   <= next_run && !next_mode && !next_tx_full;
      term_out_valid <= next_tx_full && !next_mode;
    end
  end

  // maintenance cycle on the internal cpu bus, cpu halted only [R16] [R17]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mstate       <= M_IDLE;
      mcnt         <= '0;
      ib_ctrl      <= '0;
      ib_data_oe_n <= 1'b1;
    end else if (clk_en) begin
      case (mstate)
        M_IDLE: begin
          if (acc && (cmd.code == CMD_MAINT_RD || cmd.code == CMD_MAINT_WR)) begin
            mstate        <= M_DRIVE;
            mcnt          <= CNT_W'(1);
            ib_ctrl.req   <= 1'b1; // [R16]
            ib_ctrl.write <= cmd.code == CMD_MAINT_WR;
            ib_ctrl.space <= cmd.space; // [R17]
            ib_ctrl.addr  <= cmd.addr;
            ib_data_oe_n  <= cmd.code != CMD_MAINT_WR; // [R16]
          end
        end
        M_DRIVE: begin
          if (mcnt == CNT_W'(MAINT_CYCLES)) begin
            mstate <= M_SAMPLE;
          end else begin
            mcnt <= mcnt + CNT_W'(1);
          end
        end
        M_SAMPLE: begin
          mstate       <= M_DONE;
          ib_ctrl      <= '0;
          ib_data_oe_n <= 1'b1;
        end
        M_DONE: begin
          mstate <= M_IDLE;
        end
        default: begin
          mstate       <= M_IDLE;
          ib_ctrl      <= '0;
          ib_data_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // scan bus: load, then one shift per read of the capture [R15] [R20]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scan_load   <= 1'b0;
      scan_clk    <= 1'b0;
      scan_busy   <= 1'b0;
      scan_cnt    <= '0;
      scan_unread <= 1'b0;
    end else if (clk_en) begin
      scan_load <= acc && cmd.code == CMD_SCAN_LOAD;
      scan_clk  <= acc && cmd.code == CMD_SCAN_SHIFT;
      if (acc && cmd.code == CMD_SCAN_SHIFT) begin
        scan_busy <= 1'b1;
        scan_cnt  <= '0;
      end else if (scan_sample) begin
        scan_busy <= 1'b0;
      end else if (scan_busy) begin
        scan_cnt <= scan_cnt + CNT_W'(1);
      end
      // the sample sets the flag; a read in the same cycle cannot hit it
      if (scan_sample) begin
        scan_unread <= 1'b1;
      end else if (acc && cmd.code == CMD_SCAN_READ) begin
        scan_unread <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_done    <= 1'b0;
      cmd_refused <= 1'b0;
      rsp_data    <= DATA_ZERO;
    end else if (clk_en) begin
      cmd_done    <= imm_done || scan_sample || mstate == M_DONE;
      cmd_refused <= refuse;
      if (imm_done && cmd.code == CMD_SHOW) begin
        rsp_data <= {{(DATA_W-2){1'b0}}, next_mode, next_run}; // [R21]
      end else if (imm_done && cmd.code == CMD_SCAN_READ) begin
        rsp_data <= {{(DATA_W-SCAN_LANES){1'b0}}, capture}; // [R20]
      end else if (mstate == M_DONE) begin
        rsp_data <= from_cpu_data; // [R19]
      end
    end
  end

  AST_HALT_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    $fell(cpu_run) |-> $past(cmd_mode) || $past(cpu_error_halt))
    else $error("cpu halted outside command mode without an error");

  AST_ERR_CMD: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    cpu_error_halt && clk_en |=> !cpu_run && cmd_mode)
    else $error("error halt did not force command mode");

  AST_PROG_REFUSE: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    cmd.valid && clk_en && !cmd_mode && cmd.code != CMD_ESCAPE |=> cmd_refused && !cmd_done)
    else $error("command taken in program mode");

  AST_CONT_PROG: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    acc && cmd.code == CMD_CONTINUE && !cpu_error_halt |=> cpu_run && !cmd_mode)
    else $error("continue did not enter program mode");

  AST_RUN_LIMIT: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    cmd.valid && clk_en && cpu_run && cmd_mode && !run_ok |=> cmd_refused)
    else $error("cpu-dependent command taken while running");

  AST_NO_PASS: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    cmd_mode |-> !cpu_tx_ready && !term_in_ready && !term_out_valid)
    else $error("cpu traffic open in command mode");

  AST_NO_HALT_PROG: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    !cpu_run |-> cmd_mode)
    else $error("halted cpu with program mode");

  AST_CHAR_FWD: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    acc_term |=> to_cpu_full && to_cpu_data[UNIT_W+CHAR_W-1:0] == $past(term_in))
    else $error("terminal character not loaded into to-cpu register");

  AST_MAINT_HOLD: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [R16]
    $rose(ib_ctrl.req) |-> ib_ctrl.req [*5] ##1 !ib_ctrl.req)
    else $error("maintenance request held for wrong length");

  AST_MAINT_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    !ib_data_oe_n |-> ib_ctrl.req && ib_ctrl.write)
    else $error("bus data driven outside a maintenance write");

  AST_MAINT_HALTED: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
    ib_ctrl.req |-> !cpu_run)
    else $error("maintenance cycle with cpu running");

  AST_SCAN_READ: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [R20]
    scan_clk |-> ##[1:8] cmd_done ##1 (scan_unread && !scan_clk))
    else $error("scan shift not captured in time");
endmodule : console_mode_bridge

/* File: rtl/pin_sync.sv */
module pin_sync
  import console_bridge_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pin_sync

/* File: rtl/scan_capture.sv */
module scan_capture
  import console_bridge_pkg::*;
#(
  parameter int LANES = SCAN_LANES
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             sample,
  input  wire logic [LANES-1:0] lanes,
  output logic      [LANES-1:0] capture
);
  // one serial bit per shift register lands in its own capture bit
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        capture[i] <= 1'b0;
      end else if (clk_en && sample) begin
        capture[i] <= lanes[i];
      end
    end
  end
endmodule : scan_capture
